/* File: hw/disk_cmd_exec.sv */
/*
 Task-file registers and command execution for diagnostic, cache flush,
 48-bit cache flush and single-track format.
 Assumes the host adapter strobes the task file on clk_sys, and that the
 diagnostic, cache and media helpers answer on clk_sys as well.
*/
// Overview of operation
// RULE_01: Opcode 90h runs built-in diagnostics and stores the outcome in the error register.
// RULE_02: After diagnostics the error register holds a result code, not error flags.
// RULE_03: Host reads that error value as a code, not as separate flags.
// RULE_04: Opcode E7h writes pending cache to media, then reports status 50h.
// RULE_05: Opcode EAh reports good status only after all cache is on media.
// RULE_06: Opcode 50h formats exactly one logical track, destroying its data.
// RULE_07: Formatting writes zeros to every good sector of that track.
// RULE_08: Formatting does no read-back check of the zeroed sectors.
// RULE_09: Without LBA mode, host puts cylinder number in high and mid registers.
// RULE_10: Without LBA mode, host puts head number in device head field.
// RULE_11: In LBA mode, host puts address bits 0-7 in low register.
// RULE_12: In LBA mode, bits 8-15 go to mid, bits 16-23 to high.
// RULE_13: In LBA mode, address bits 24-27 go in device head field.
// RULE_14: Busy stays set until final status and error values are in place.
`timescale 1ns/1ns
`default_nettype none
`include "disk_cmd_regs.svh"

module disk_cmd_exec (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] tf_addr,
    input wire logic [7:0] tf_wdata,
    input wire logic tf_wr,
    input wire logic tf_rd,
    output logic [7:0] tf_rdata,
    output logic busy,
    output logic diag_start,
    input wire logic diag_done,
    input wire logic [7:0] diag_code,
    output logic flush_req,
    input wire logic flush_done,
    input wire logic flush_fail,
    output logic wr_req,
    output logic [27:0] wr_lba,
    output logic wr_zero,
    input wire logic wr_ack,
    input wire logic wr_fail,
    input wire logic sector_bad
);
    import disk_cmd_pkg::*;

    // =============================================================
    // Helpers

    // Opcodes this block executes; anything else is aborted
    function automatic logic is_known(input logic [7:0] op);
        is_known = (op == `OP_DIAG) || (op == `OP_FLUSH) ||
                   (op == `OP_FLUSH_EXT) || (op == `OP_FMT_TRACK);
    endfunction : is_known

    // First block of the track that the task file selects
    function automatic logic [27:0] track_start(input logic [7:0] dev,
        input logic [7:0] hi, input logic [7:0] mid, input logic [7:0] lo);
        logic [27:0] blk;
        logic [27:0] trk;
        blk = `LBA_ZERO;
        trk = `LBA_ZERO;
        if (dev[`DEV_LBA_BIT]) begin
            // RULE_11 low byte bits 0-7
            // RULE_12 mid and high bytes
            // RULE_13 head field bits 24-27
            blk = {dev[3:0], hi, mid, lo};
            trk = blk / `SECT_PER_TRACK;
        end else begin
            // RULE_09 cylinder in high and mid
            // RULE_10 head in device field
            trk = {12'h000, hi, mid} * `HEADS_PER_CYL + {24'h000000, dev[3:0]};
        end
        // RULE_06 whole track containing the block
        track_start = trk * `SECT_PER_TRACK;
    endfunction : track_start

    // =============================================================
    // State
    cmd_state_type state_q, state_d;
    logic busy_q, busy_d;
    logic [6:0] status_q, status_d; // Status without BSY, which busy_q supplies
    logic [7:0] err_q, err_d;
    logic [7:0] feat_q, feat_d, scnt_q, scnt_d, lbal_q, lbal_d;
    logic [7:0] lbam_q, lbam_d, lbah_q, lbah_d, dev_q, dev_d;
    logic [7:0] rdata_q, rdata_d;
    logic diag_q, diag_d, start_q, start_d;
    job_kind_type kind_q, kind_d;
    logic [27:0] base_q, base_d;
    logic cmd_take;

    job_if job_bus ();

    // Command accepted only while idle; the host must not write a busy device
    assign cmd_take = tf_wr && tf_addr == `TF_CMD && state_q == CMD_IDLE;

    // =============================================================
    // Next-state logic for task file and command sequencing
    always_comb begin
        state_d = state_q;
        busy_d = busy_q;
        status_d = status_q;
        err_d = err_q;
        feat_d = feat_q;
        scnt_d = scnt_q;
        lbal_d = lbal_q;
        lbam_d = lbam_q;
        lbah_d = lbah_q;
        dev_d = dev_q;
        rdata_d = rdata_q;
        diag_d = 1'b0;
        start_d = 1'b0;
        kind_d = kind_q;
        base_d = base_q;
        // Parameter writes are ignored during execution so inputs stay stable
        if (tf_wr && state_q == CMD_IDLE) begin
            unique case (tf_addr)
                `TF_ERR: feat_d = tf_wdata;
                `TF_SCNT: scnt_d = tf_wdata;
                `TF_LBAL: lbal_d = tf_wdata;
                `TF_LBAM: lbam_d = tf_wdata;
                `TF_LBAH: lbah_d = tf_wdata;
                `TF_DEV: dev_d = tf_wdata;
                `TF_DATA, `TF_CMD: begin
                end
            endcase
        end
        unique case (state_q)
            CMD_IDLE: begin
                if (cmd_take) begin
                    // RULE_14 busy from command write
                    busy_d = 1'b1;
                    if (tf_wdata == `OP_DIAG) begin
                        diag_d = 1'b1;
                        state_d = CMD_DIAG;
                    end else if (is_known(tf_wdata)) begin
                        start_d = 1'b1;
                        kind_d = (tf_wdata == `OP_FMT_TRACK) ? JOB_FORMAT : JOB_FLUSH;
                        base_d = track_start(dev_q, lbah_q, lbam_q, lbal_q);
                        state_d = CMD_JOB;
                    end else begin
                        state_d = CMD_ABORT;
                    end
                end
            end
            // RULE_01 run diagnostics, keep outcome
            // RULE_02 error register takes the code
            // RULE_03 code loaded whole, no flag mixing
            CMD_DIAG: begin
                if (diag_done) begin
                    err_d = diag_code;
                    status_d = 7'(`ST_DIAG);
                    busy_d = 1'b0;
                    state_d = CMD_IDLE;
                end
            end
            // RULE_04 status 50h after flush
            // RULE_05 good status only after commit
            CMD_JOB: begin
                if (job_bus.done) begin
                    unique case (job_bus.result)
                        RES_OK: begin
                            status_d = 7'(`ST_GOOD);
                            err_d = `ERR_NONE;
                        end
                        RES_CACHE_FAIL: begin
                            status_d = 7'(`ST_ABORT);
                            err_d = `ERR_ABT;
                        end
                        default: begin
                            status_d = 7'(`ST_FMT_FAULT);
                            err_d = `ERR_IDN;
                        end
                    endcase
                    // RULE_14 busy clears with final values
                    busy_d = 1'b0;
                    state_d = CMD_IDLE;
                end
            end
            CMD_ABORT: begin
                status_d = 7'(`ST_ABORT);
                err_d = `ERR_ABT;
                busy_d = 1'b0;
                state_d = CMD_IDLE;
            end
        endcase
        // Read data is registered, so it follows the read strobe by one cycle
        if (tf_rd) begin
            unique case (tf_addr)
                `TF_DATA: rdata_d = `BYTE_ZERO;
                `TF_ERR: rdata_d = err_q;
                `TF_SCNT: rdata_d = scnt_q;
                `TF_LBAL: rdata_d = lbal_q;
                `TF_LBAM: rdata_d = lbam_q;
                `TF_LBAH: rdata_d = lbah_q;
                `TF_DEV: rdata_d = dev_q;
                `TF_CMD: rdata_d = {busy_q, status_q};
            endcase
        end
    end

    // Registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= CMD_IDLE;
            busy_q <= 1'b0;
            status_q <= 7'(`ST_RESET);
            err_q <= `ERR_NONE;
            feat_q <= `BYTE_ZERO;
            scnt_q <= `BYTE_ZERO;
            lbal_q <= `BYTE_ZERO;
            lbam_q <= `BYTE_ZERO;
            lbah_q <= `BYTE_ZERO;
            dev_q <= `DEV_RESET;
            rdata_q <= `BYTE_ZERO;
            diag_q <= 1'b0;
            start_q <= 1'b0;
            kind_q <= JOB_FLUSH;
            base_q <= `LBA_ZERO;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            status_q <= status_d;
            err_q <= err_d;
            feat_q <= feat_d;
            scnt_q <= scnt_d;
            lbal_q <= lbal_d;
            lbam_q <= lbam_d;
            lbah_q <= lbah_d;
            dev_q <= dev_d;
            rdata_q <= rdata_d;
            diag_q <= diag_d;
            start_q <= start_d;
            kind_q <= kind_d;
            base_q <= base_d;
        end
    end

    assign job_bus.start = start_q;
    assign job_bus.kind = kind_q;
    assign job_bus.base = base_q;
    assign tf_rdata = rdata_q;
    assign busy = busy_q;
    assign diag_start = diag_q;

    // =============================================================
    // Media engine
    media_engine u_engine (
        .clk_sys(clk_sys),
        .rst(rst),
        .job(job_bus.eng),
        .flush_req(flush_req),
        .flush_done(flush_done),
        .flush_fail(flush_fail),
        .wr_req(wr_req),
        .wr_lba(wr_lba),
        .wr_zero(wr_zero),
        .wr_ack(wr_ack),
        .wr_fail(wr_fail),
        .sector_bad(sector_bad)
    );

    // =============================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_bad_op;
        cmd_take && !is_known(tf_wdata);
    endsequence
    sequence s_abort_done;
        busy_q ##1 (!busy_q && status_q == 7'(`ST_ABORT) && err_q == `ERR_ABT);
    endsequence

    // RULE_14 busy follows a command
    a_cmd_sets_busy: assert property (cmd_take |=> busy_q) // RULE_14
        else $error("busy not set after command");
    // RULE_14 busy only drops on completion
    a_busy_drop_final: assert property ($fell(busy_q) |-> $past(state_q) != CMD_IDLE
        && state_q == CMD_IDLE) // RULE_14
        else $error("busy dropped outside completion");
    a_bad_op_abort: assert property (s_bad_op |=> s_abort_done) // RULE_14
        else $error("unknown opcode not aborted");
    // RULE_02 diagnostic code replaces flags
    a_diag_code_load: assert property (state_q == CMD_DIAG && diag_done
        |=> err_q == $past(diag_code) && !busy_q && status_q == 7'(`ST_DIAG)) // RULE_02
        else $error("diagnostic code not loaded");
    // RULE_01 diagnostic started on 90h
    a_diag_starts: assert property (cmd_take && tf_wdata == `OP_DIAG
        |=> diag_start ##1 !diag_start) // RULE_01
        else $error("diagnostic not started");
    // RULE_04 good flush ends with 50h
    a_flush_good_status: assert property (state_q == CMD_JOB && kind_q == JOB_FLUSH
        && job_bus.done && job_bus.result == RES_OK
        |=> {1'b0, status_q} == `ST_GOOD && !busy_q) // RULE_04
        else $error("flush did not end with good status");
    // RULE_05 no completion before flush done
    a_flush_no_early: assert property (state_q == CMD_JOB && kind_q == JOB_FLUSH
        && !job_bus.done |=> busy_q) // RULE_05
        else $error("flush completed early");
    // RULE_06 format base aligned to track
    a_fmt_base_aligned: assert property (job_bus.start && kind_q == JOB_FORMAT
        |-> base_q % `SECT_PER_TRACK == `LBA_ZERO) // RULE_06
        else $error("format base not on a track boundary");
endmodule : disk_cmd_exec

`default_nettype wire

/* File: shared/disk_cmd_regs.svh */
/*
 Holds the task-file register numbers, opcodes, status and error values and
 the track geometry used by the command logic.
 Assumes it is included by bare name by the command modules.
*/
`ifndef DISK_CMD_REGS_SVH
`define DISK_CMD_REGS_SVH

// =============================================================
// Task-file register numbers
`define TF_DATA 3'h0
`define TF_ERR 3'h1
`define TF_SCNT 3'h2
`define TF_LBAL 3'h3
`define TF_LBAM 3'h4
`define TF_LBAH 3'h5
`define TF_DEV 3'h6
`define TF_CMD 3'h7

// =============================================================
// Opcodes
`define OP_DIAG 8'h90
`define OP_FLUSH 8'hE7
`define OP_FLUSH_EXT 8'hEA
`define OP_FMT_TRACK 8'h50

// =============================================================
// Status and error values
`define ST_RESET 8'h50
`define ST_GOOD 8'h50
`define ST_ABORT 8'h51
`define ST_FMT_FAULT 8'h71
`define ST_DIAG 8'h00
`define ST_BSY_BIT 7
`define ERR_NONE 8'h00
`define ERR_ABT 8'h04
`define ERR_IDN 8'h10
`define BYTE_ZERO 8'h00

// =============================================================
// Device register fields and track geometry
`define DEV_RESET 8'hA0
`define DEV_LBA_BIT 6
`define SECT_PER_TRACK 28'd64
`define HEADS_PER_CYL 28'd16
`define SECT_LAST 6'h3F
`define SECT_FIRST 6'h00
`define LBA_ZERO 28'h0000000
`define LBA_STEP 28'h0000001

`endif

/* File: shared/disk_cmd_pkg.sv */
/*
 Holds the state and job types shared by the command modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package disk_cmd_pkg;
    typedef enum logic [1:0] {
        CMD_IDLE = 2'b00,
        CMD_DIAG = 2'b01,
        CMD_JOB = 2'b10,
        CMD_ABORT = 2'b11
    } cmd_state_type;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_FLUSH = 2'b01,
        ENG_SEEK = 2'b10,
        ENG_WRITE = 2'b11
    } eng_state_type;

    typedef enum logic {
        JOB_FLUSH = 1'b0,
        JOB_FORMAT = 1'b1
    } job_kind_type;

    typedef enum logic [1:0] {
        RES_OK = 2'b00,
        RES_CACHE_FAIL = 2'b01,
        RES_MEDIA_FAIL = 2'b10
    } job_result_type;
endpackage : disk_cmd_pkg

`default_nettype wire

/* File: shared/job_if.sv */
/*
 Carries one media job from the command logic to the media engine.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface job_if;
    import disk_cmd_pkg::*;
    logic start;
    job_kind_type kind;
    logic [27:0] base;
    logic done;
    job_result_type result;
    modport ctl (output start, output kind, output base, input done, input result);
    modport eng (input start, input kind, input base, output done, output result);
endinterface : job_if

`default_nettype wire

/* File: hw/media_engine.sv */
/*
 Runs a cache flush or the zeroing of one track on behalf of the command logic.
 Assumes the cache, defect map and sector writer answer on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
`include "disk_cmd_regs.svh"

module media_engine (
    input wire logic clk_sys,
    input wire logic rst,
    job_if.eng job,
    output logic flush_req,
    input wire logic flush_done,
    input wire logic flush_fail,
    output logic wr_req,
    output logic [27:0] wr_lba,
    output logic wr_zero,
    input wire logic wr_ack,
    input wire logic wr_fail,
    input wire logic sector_bad
);
    import disk_cmd_pkg::*;

    eng_state_type state_q, state_d;
    logic [5:0] idx_q, idx_d;
    logic [27:0] lba_q, lba_d;
    logic fail_q, fail_d, done_q, done_d, flush_q, flush_d, wr_q, wr_d;
    job_result_type res_q, res_d;

    // =============================================================
    // Next-state logic; one sector at a time so the defect lookup stays simple
    always_comb begin
        logic step;
        step = 1'b0;
        state_d = state_q;
        idx_d = idx_q;
        lba_d = lba_q;
        fail_d = fail_q;
        done_d = 1'b0;
        flush_d = flush_q;
        wr_d = wr_q;
        res_d = res_q;
        unique case (state_q)
            ENG_IDLE: begin
                if (job.start && job.kind == JOB_FLUSH) begin
                    flush_d = 1'b1;
                    state_d = ENG_FLUSH;
                end else if (job.start) begin
                    idx_d = `SECT_FIRST;
                    lba_d = job.base;
                    fail_d = 1'b0;
                    state_d = ENG_SEEK;
                end
            end
            // RULE_04 cache written to media
            ENG_FLUSH: begin
                if (flush_done) begin
                    flush_d = 1'b0;
                    done_d = 1'b1;
                    res_d = flush_fail ? RES_CACHE_FAIL : RES_OK;
                    state_d = ENG_IDLE;
                end
            end
            // RULE_07 zero good sectors only
            ENG_SEEK: begin
                if (sector_bad) begin
                    step = 1'b1;
                end else begin
                    wr_d = 1'b1;
                    state_d = ENG_WRITE;
                end
            end
            // RULE_08 no read-back pass
            ENG_WRITE: begin
                if (wr_ack) begin
                    wr_d = 1'b0;
                    fail_d = fail_q | wr_fail;
                    step = 1'b1;
                    state_d = ENG_SEEK;
                end
            end
        endcase
        // RULE_06 exactly one track
        if (step && idx_q == `SECT_LAST) begin
            done_d = 1'b1;
            res_d = (fail_q | (wr_ack & wr_fail)) ? RES_MEDIA_FAIL : RES_OK;
            state_d = ENG_IDLE;
        end else if (step) begin
            idx_d = idx_q + 6'h01;
            lba_d = lba_q + `LBA_STEP;
        end
    end

    // Registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ENG_IDLE;
            idx_q <= `SECT_FIRST;
            lba_q <= `LBA_ZERO;
            fail_q <= 1'b0;
            done_q <= 1'b0;
            flush_q <= 1'b0;
            wr_q <= 1'b0;
            res_q <= RES_OK;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            lba_q <= lba_d;
            fail_q <= fail_d;
            done_q <= done_d;
            flush_q <= flush_d;
            wr_q <= wr_d;
            res_q <= res_d;
        end
    end

    assign job.done = done_q;
    assign job.result = res_q;
    assign flush_req = flush_q;
    assign wr_req = wr_q;
    assign wr_lba = lba_q;
    assign wr_zero = wr_q; // Write data pattern is all zeros for every format write

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // RULE_07 zero pattern with every write
    a_zero_fill_write: assert property (wr_req |-> wr_zero && state_q == ENG_WRITE) // RULE_07
        else $error("format write without zero fill");
    // RULE_07 defective sector skipped
    a_no_bad_write: assert property ($rose(wr_req) |-> !$past(sector_bad)) // RULE_07
        else $error("write issued to a defective sector");
    // RULE_04 flush held until cache answers
    a_flush_req_held: assert property (flush_req && !flush_done |=> flush_req) // RULE_04
        else $error("flush request dropped early");
    // RULE_08 no read after the last write
    a_no_readback: assert property (job.done && $past(state_q) != ENG_FLUSH
        |-> ($past(state_q) == ENG_WRITE || $past(state_q) == ENG_SEEK) && !wr_req) // RULE_08
        else $error("format did not end after its last write");
endmodule : media_engine

`default_nettype wire

/* File: verif/media_model.sv */
/*
 Model of the helpers behind the command logic: diagnostic unit, write
 cache and sector writer with its defect map.
 Assumes requests arrive on clk_sys; answers other than the defect map change at the falling edge.
*/
`timescale 1ns/1ns
`default_nettype none

module media_model (
    input wire logic clk_sys,
    input wire logic clr,
    input wire logic [3:0] lat,
    input wire logic [7:0] code,
    input wire logic fail_cache,
    input wire logic fail_wr,
    input wire logic [27:0] bad_lba,
    input wire logic diag_start,
    output logic diag_done,
    output logic [7:0] diag_code,
    input wire logic flush_req,
    output logic flush_done,
    output logic flush_fail,
    input wire logic wr_req,
    input wire logic [27:0] wr_lba,
    input wire logic wr_zero,
    output logic wr_ack,
    output logic wr_fail,
    output logic sector_bad
);
    logic dp;
    logic [3:0] cnt;
    int n_wr;
    int n_fl;
    int n_nz;
    logic [27:0] first_lba;
    logic [27:0] last_lba;

    // =========================================================
    // Defect map answers in the same cycle
    assign sector_bad = (wr_lba == bad_lba);

    // Side data is inverted outside its strobe so stale values never pass
    always @(negedge clk_sys) begin
        diag_done <= 1'b0;
        flush_done <= 1'b0;
        wr_ack <= 1'b0;
        diag_code <= ~code;
        flush_fail <= ~fail_cache;
        wr_fail <= ~fail_wr;
        if (clr) begin
            dp <= 1'b0;
            cnt <= 4'h0;
            n_wr <= 0;
            n_fl <= 0;
            n_nz <= 0;
        end else if (dp || (flush_req && !flush_done) || (wr_req && !wr_ack)) begin
            cnt <= cnt + 4'h1;
            if (cnt == lat) begin
                cnt <= 4'h0;
                if (dp) begin
                    dp <= 1'b0;
                    diag_done <= 1'b1;
                    diag_code <= code;
                end else if (flush_req) begin
                    flush_done <= 1'b1;
                    flush_fail <= fail_cache;
                    n_fl <= n_fl + 1;
                end else begin
                    wr_ack <= 1'b1;
                    wr_fail <= fail_wr;
                    n_wr <= n_wr + 1;
                    if (n_wr == 0) first_lba <= wr_lba;
                    last_lba <= wr_lba;
                    if (wr_zero !== 1'b1) n_nz <= n_nz + 1;
                end
            end
        end
        if (!clr && diag_start) dp <= 1'b1;
    end
endmodule : media_model

`default_nettype wire

/* File: verif/tb.sv */
/*
 Self-checking bench for the command logic, driving the task file.
 Assumes the helper model answers diagnostic, flush and write requests.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb;
    logic clk_sys, rst, tf_wr, tf_rd, clr, fail_cache, fail_wr, busy, diag_start, diag_done;
    logic flush_req, flush_done, flush_fail, wr_req, wr_zero, wr_ack, wr_fail, sector_bad;
    logic [2:0] tf_addr;
    logic [7:0] tf_wdata, tf_rdata, code, rd_val, diag_code;
    logic [3:0] lat;
    logic [27:0] bad_lba, wr_lba;
    int err_total = 0;
    int n_compared = 0;

    disk_cmd_exec disk_cmd_exec_i (.clk_sys(clk_sys), .rst(rst), .tf_addr(tf_addr),
        .tf_wdata(tf_wdata), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_rdata(tf_rdata), .busy(busy),
        .diag_start(diag_start), .diag_done(diag_done), .diag_code(diag_code),
        .flush_req(flush_req), .flush_done(flush_done), .flush_fail(flush_fail),
        .wr_req(wr_req), .wr_lba(wr_lba), .wr_zero(wr_zero), .wr_ack(wr_ack),
        .wr_fail(wr_fail), .sector_bad(sector_bad));
    media_model media_model_i (.clk_sys(clk_sys), .clr(clr), .lat(lat), .code(code),
        .fail_cache(fail_cache), .fail_wr(fail_wr), .bad_lba(bad_lba),
        .diag_start(diag_start), .diag_done(diag_done), .diag_code(diag_code),
        .flush_req(flush_req), .flush_done(flush_done), .flush_fail(flush_fail),
        .wr_req(wr_req), .wr_lba(wr_lba), .wr_zero(wr_zero), .wr_ack(wr_ack),
        .wr_fail(wr_fail), .sector_bad(sector_bad));

    // =========================================================
    // Task-file access, one strobe cycle per transfer
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        tf_addr = a;
        tf_wdata = d;
        tf_wr = 1'b1;
        @(negedge clk_sys);
        tf_wr = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a);
        @(negedge clk_sys);
        tf_addr = a;
        tf_rd = 1'b1;
        @(negedge clk_sys);
        tf_rd = 1'b0;
        rd_val = tf_rdata;
    endtask : rd_reg

    // Long commands also probe busy and a dropped write mid-run
    task automatic run_cmd(input logic [7:0] op, input logic [7:0] st, input logic [7:0] er,
                           input logic long_op);
        int n;
        // Two edges so the model sees the clear whichever process runs first
        clr = 1'b1;
        repeat (2) @(negedge clk_sys);
        clr = 1'b0;
        wr_reg(3'h7, op);
        `CHK("busy_set", 1'b1, busy)
        if (long_op) begin
            rd_reg(3'h7);
            `CHK("busy_bit", 1'b1, rd_val[7])
            wr_reg(3'h6, 8'hFF);
        end
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK("busy_clear", 1'b0, busy)
        rd_reg(3'h7);
        `CHK("status", st, rd_val)
        rd_reg(3'h1);
        `CHK("error", er, rd_val)
    endtask : run_cmd

    task automatic chk_fmt(input logic [27:0] first, input logic [27:0] last, input int cnt);
        `CHK("first_lba", first, media_model_i.first_lba)
        `CHK("last_lba", last, media_model_i.last_lba)
        `CHK("writes", cnt, media_model_i.n_wr)
        `CHK("nonzero", 0, media_model_i.n_nz)
    endtask : chk_fmt

    task automatic print_verdict;
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Runs take under 3000 cycles; the limit leaves wide margin
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        print_verdict();
    end

    initial begin
        {rst, clr} = 2'b11;
        {tf_wr, tf_rd, fail_cache, fail_wr} = 4'h0;
        tf_addr = 3'h0;
        tf_wdata = 8'h00;
        lat = 4'h0;
        code = 8'h00;
        bad_lba = 28'hFFFFFFF;
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        rd_reg(3'h7);
        `CHK("rst_status", 8'h50, rd_val)
        rd_reg(3'h1);
        `CHK("rst_error", 8'h00, rd_val)
        rd_reg(3'h6);
        `CHK("rst_device", 8'hA0, rd_val)
        rd_reg(3'h0);
        `CHK("data_reg", 8'h00, rd_val)
        // Diagnostic codes land whole, fast and slow helper
        for (int i = 0; i < 2; i++) begin
            lat = 4'(i * 9);
            code = (i == 1) ? 8'h81 : 8'h01;
            run_cmd(8'h90, 8'h00, code, 1'b0);
        end
        // Both flush opcodes, with and without a cache failure
        for (int i = 0; i < 4; i++) begin
            fail_cache = i[1];
            lat = 4'(i * 3);
            run_cmd(i[0] ? 8'hEA : 8'hE7, i[1] ? 8'h51 : 8'h50, i[1] ? 8'h04 : 8'h00, 1'b0);
            `CHK("flushes", 1, media_model_i.n_fl)
        end
        // Cylinder 2, head 3: track 35, sector 5 defective
        lat = 4'h2;
        bad_lba = 28'h00008C5;
        wr_reg(3'h5, 8'h00);
        wr_reg(3'h4, 8'h02);
        wr_reg(3'h6, 8'hA3);
        run_cmd(8'h50, 8'h50, 8'h00, 1'b1);
        chk_fmt(28'h00008C0, 28'h00008FF, 63);
        rd_reg(3'h6);
        `CHK("dev_kept", 8'hA3, rd_val)
        // Block mode, last sector defective, every write failing
        fail_wr = 1'b1;
        bad_lba = 28'h123457F;
        wr_reg(3'h3, 8'h67);
        wr_reg(3'h4, 8'h45);
        wr_reg(3'h5, 8'h23);
        wr_reg(3'h6, 8'hE1);
        run_cmd(8'h50, 8'h71, 8'h10, 1'b1);
        chk_fmt(28'h1234540, 28'h123457E, 63);
        run_cmd(8'hC5, 8'h51, 8'h04, 1'b0);
        print_verdict();
    end
endmodule : tb

`default_nettype wire
